// ==== src/dmac_channel.sv ====
`timescale 1ns/1ps
module dmac_channel
  import dmac_pkg::*;
#(
  parameter int NUM_CH = 8,
  parameter int CH_ID = 7,
  parameter int PAW = 6
)
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PAW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output dmac_mreq_s mreq,
  input wire dmac_mrsp_s mrsp,
  input wire logic [NUM_CH-1:0] peer_req,
  input wire logic [NUM_CH*3-1:0] peer_prio,
  output logic bus_req,
  output logic [2:0] channel_priority,
  input wire logic dreq,
  output logic dreq_ack,
  output logic irq_pulse,
  output logic [15:0] item_index
);

  // Bits needed to name one channel; a lone channel still needs one bit.
  localparam int CW = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;

  // ====================================================
  // All state of the channel in one record.
  // Registers, sequencer state and the registered bus request live together.
  // Keeping them in one record makes the reset value a single assignment.
  typedef struct packed {
    dmac_state_e st;
    logic [15:0] ctrl;
    logic [15:0] thr;
    logic [15:0] len;
    logic [15:0] idx;
    logic [31:0] a_start;
    logic [31:0] b_start;
    logic [31:0] data;
    logic [31:0] prdata;
    dmac_mreq_s mreq;
    logic irq;
    logic ack;
  } dmac_regs_s;

  dmac_regs_s r_q; // Registered state.
  dmac_regs_s r_d; // Next state.

  // ====================================================
  // Helper functions.

  // Turns the width field into a byte shift; the reserved code acts as 4 bytes.
  // Treating the reserved code as the widest size keeps addresses aligned.
  function automatic logic [1:0] width_shift(input logic [1:0] wf);
    logic [1:0] s;
    // Word items are the default; narrower codes override below.
    s = 2'd2;
    if (wf == 2'b00)
    begin
      s = 2'd0;
    end
    else if (wf == 2'b01)
    begin
      s = 2'd1;
    end
    return s;
  endfunction

  // Forms an item address from start, index, increment and width.
  // The sum is cut to 32 bits, so an address wraps at the top of memory.
  function automatic logic [31:0] item_addr(input logic [31:0] start,
                                            input logic [15:0] ix,
                                            input logic inc,
                                            input logic [1:0] wf);
    logic [31:0] off;
    // The index is widened before the shift so no offset bit is lost.
    off = 32'({16'h0000, ix} << width_shift(wf));
    return inc ? start + off : start;
  endfunction

  // Picks the winning requester: greatest priority, lowest number on a tie.
  // A channel that is not asking never wins over one that is; with no requester the result is channel 0.
  function automatic logic [CW-1:0] pick(input logic [NUM_CH-1:0] rq,
                                         input logic [NUM_CH*3-1:0] pr);
    logic [CW-1:0] w;
    logic [2:0] best;
    logic found;
    w = '0;
    best = 3'h0;
    found = 1'b0;
    // Walking downward with >= lets the lower number take a tie.
    for (int i = NUM_CH - 1; i >= 0; i--)
    begin
      if (rq[i] && (!found || pr[i*3 +: 3] >= best))
      begin
        w = CW'(i);
        best = pr[i*3 +: 3];
        found = 1'b1;
      end
    end
    return w;
  endfunction

  // Register read mux; reserved bits read as zero.
  // Every one of the eight indices names a register, so all decode.
  function automatic logic [15:0] reg_read(input dmac_regs_s s,
                                           input logic [2:0] ix);
    logic [15:0] v;
    v = 16'h0000;
    case (ix)
      IX_ASTL: v = s.a_start[15:0];
      IX_ASTH: v = s.a_start[31:16];
      IX_BSTL: v = s.b_start[15:0];
      IX_BSTH: v = s.b_start[31:16];
      IX_THR: v = s.thr;
      IX_LEN: v = s.len;
      IX_CTRL: v = s.ctrl & CTRL_MASK;
      IX_IDX: v = s.idx;
      default: v = 16'h0000;
    endcase
    return v;
  endfunction

  // ====================================================
  // Arbitration among all channels.
  logic [NUM_CH-1:0] all_req; // Requests with this channel's own bit inserted.
  logic [NUM_CH*3-1:0] all_prio; // Priorities with this channel's own field.
  logic granted; // This channel wins the current arbitration.
  logic own_req; // This channel asks for the bus this cycle.

  assign own_req = (r_q.st == ST_ARB);

  // Combines the peer view with this channel's own request and priority.
  // The own slot of the peer vectors is ignored and refilled here.
  always_comb
  begin
    all_req = peer_req;
    all_prio = peer_prio;
    all_req[CH_ID] = own_req;
    all_prio[CH_ID*3 +: 3] = r_q.ctrl[B_PRIO +: 3];
  end

  // Only the winner of the whole field may drive the bus in the next cycle.
  assign granted = own_req && (pick(all_req, all_prio) == CW'(CH_ID));

  // ====================================================
  // Bus slave decode.
  logic apb_wr; // Write in its access phase.
  logic apb_setup; // Setup cycle of any transfer.
  logic apb_hit; // Address names a register of the channel.
  logic [2:0] apb_ix; // Register index from the byte address.

  // Each register sits in its own aligned word of the bus space.
  // Byte lanes other than word starts, and the upper half, are unmapped.
  assign apb_ix = paddr[4:2];
  assign apb_hit = (paddr[1:0] == 2'b00) && (paddr[PAW-1:5] == '0);
  assign apb_wr = psel && penable && pwrite && apb_hit;
  assign apb_setup = psel && !penable;

  // ====================================================
  // Next-state logic: sequencer first, then software writes override it.
  always_comb
  begin
    logic trig;
    logic last;
    // Trigger mode and the last item steer most of the branches below.
    trig = r_q.ctrl[B_TRIG];
    last = (r_q.idx == r_q.len);
    r_d = r_q;
    r_d.irq = 1'b0;
    r_d.ack = 1'b0;
    case (r_q.st)
      // Off: the sequencer does nothing until the enable bit is set.
      ST_IDLE:
      begin
        if (r_q.ctrl[B_ON])
        begin
          r_d.st = trig ? ST_WAIT : ST_ARB;
        end
      end
      // Trigger mode: one item per peripheral request.
      ST_WAIT:
      begin
        // Clearing enable here abandons the transfer and rewinds the index.
        if (!r_q.ctrl[B_ON])
        begin
          r_d.st = ST_IDLE;
          r_d.idx = RST_IDX;
        end
        else if (dreq)
        begin
          r_d.st = ST_ARB;
        end
      end
      // Asks the arbiter; a fill after its first fetch goes straight to stores.
      ST_ARB:
      begin
        // No bus access is open yet, so an abort is safe here too.
        if (!r_q.ctrl[B_ON])
        begin
          r_d.st = ST_IDLE;
          r_d.idx = RST_IDX;
        end
        else if (granted)
        begin
          if (r_q.ctrl[B_FILL] && r_q.idx != RST_IDX)
          begin
            r_d.st = ST_WRITE;
          end
          else
          begin
            r_d.st = ST_READ;
          end
        end
      end
      // Fetch of one item; the value is kept for the store.
      ST_READ:
      begin
        // Read data is valid only in the cycle in which ready stands.
        if (mrsp.ready)
        begin
          r_d.data = mrsp.rdata;
          r_d.st = ST_WRITE;
        end
      end
      // Store of one item; the item ends here.
      ST_WRITE:
      begin
        if (mrsp.ready)
        begin
          // The threshold is compared before the index moves on.
          if (r_q.ctrl[B_IRQ_EN] && r_q.thr == r_q.idx)
          begin
            r_d.irq = 1'b1;
          end
          r_d.ack = trig;
          // Last item: rewind, then either wait again or switch off.
          if (last)
          begin
            r_d.idx = RST_IDX;
            if (r_q.ctrl[B_CIRC] && trig)
            begin
              r_d.st = ST_WAIT;
            end
            else
            begin
              r_d.ctrl[B_ON] = 1'b0;
              r_d.st = ST_IDLE;
            end
          end
          else
          begin
            // More items: the mode bits choose the next step.
            r_d.idx = r_q.idx + 16'h0001;
            if (trig)
            begin
              r_d.st = ST_WAIT;
            end
            else if (r_q.ctrl[B_FILL])
            begin
              r_d.st = ST_WRITE;
            end
            else if (r_q.ctrl[B_IDLE])
            begin
              r_d.st = ST_GAP;
            end
            else
            begin
              r_d.st = ST_READ;
            end
          end
        end
      end
      // One free bus cycle, then arbitration again.
      ST_GAP:
      begin
        r_d.st = r_q.ctrl[B_ON] ? ST_ARB : ST_IDLE;
        if (!r_q.ctrl[B_ON])
        begin
          r_d.idx = RST_IDX;
        end
      end
      // An illegal state code falls back to idle.
      default:
      begin
        r_d.st = ST_IDLE;
      end
    endcase

    // Software writes; a written value wins over the hardware clear of enable.
    // The read-only index and any reserved bits simply drop what is written.
    if (apb_wr)
    begin
      case (apb_ix)
        IX_ASTL: r_d.a_start[15:0] = pwdata[15:0];
        IX_ASTH: r_d.a_start[31:16] = pwdata[15:0];
        IX_BSTL: r_d.b_start[15:0] = pwdata[15:0];
        IX_BSTH: r_d.b_start[31:16] = pwdata[15:0];
        IX_THR: r_d.thr = pwdata[15:0];
        IX_LEN: r_d.len = pwdata[15:0];
        IX_CTRL: r_d.ctrl = pwdata[15:0] & CTRL_MASK;
        default: r_d.idx = r_d.idx; // The index is read-only.
      endcase
    end

    // Read data is caught in the setup cycle for the access phase.
    if (apb_setup)
    begin
      r_d.prdata = {16'h0000, reg_read(r_q, apb_ix)};
    end

    // Bus request outputs follow the next state.
    // They are registered, so the bus sees them in the cycle the state is entered.
    r_d.mreq.req = (r_d.st == ST_READ) || (r_d.st == ST_WRITE);
    r_d.mreq.we = (r_d.st == ST_WRITE);
    r_d.mreq.size = r_d.ctrl[B_WIDTH +: 2];
    r_d.mreq.wdata = r_d.data;
    // The lock keeps other masters off while a blocking copy or a fill runs.
    r_d.mreq.lock = r_d.mreq.req
                    && (r_d.ctrl[B_FILL]
                        || (!r_d.ctrl[B_TRIG] && !r_d.ctrl[B_IDLE]));
    // Stores go to the destination side, fetches to the source side.
    if (r_d.st == ST_WRITE)
    begin
      r_d.mreq.addr = item_addr(r_d.b_start, r_d.idx, r_d.ctrl[B_DST_INC],
                                r_d.ctrl[B_WIDTH +: 2]);
    end
    else
    begin
      r_d.mreq.addr = item_addr(r_d.a_start, r_d.idx, r_d.ctrl[B_SRC_INC],
                                r_d.ctrl[B_WIDTH +: 2]);
    end
  end

  // ====================================================
  // State register with asynchronous reset.
  // Everything clears at once, so no field is left undefined after reset.
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      r_q <= '{st: ST_IDLE, ctrl: RST_CTRL, thr: RST_THR, len: RST_LEN,
               idx: RST_IDX, a_start: RST_START, b_start: RST_START,
               data: 32'h0000_0000, prdata: 32'h0000_0000, mreq: '0,
               irq: 1'b0, ack: 1'b0};
    end
    else
    begin
      r_q <= r_d;
    end
  end

  // ====================================================
  // Outputs.
  // Read data comes from a flip-flop and stands until the next setup cycle.
  assign prdata = r_q.prdata;
  // Ready is tied high: every transfer is a setup and one access cycle.
  assign pready = 1'b1;
  // The error flag marks an access that is not word-aligned or lies outside the channel's eight words.
  assign pslverr = psel && penable && !apb_hit;
  assign mreq = r_q.mreq;
  assign bus_req = own_req;
  assign channel_priority = r_q.ctrl[B_PRIO +: 3];
  assign dreq_ack = r_q.ack;
  assign irq_pulse = r_q.irq;
  assign item_index = r_q.idx;

endmodule

// ==== src/dmac_pkg.sv ====
// Operation
// - Irq when threshold equals index, before increment
// - Irq only while irq enable bit set
// - Length field holds item count minus one
// - Fill mode: one fetch, many stores
// - Fill transfer holds bus, never preempted; a fill in trigger mode re-arbitrates before each item
// - Blocking mode: back-to-back, bus locked
// - Idle mode: one wait cycle after store
// - Trigger mode ignores idle bit
// - Arbiter grants highest priority field
// - Equal priority: lowest channel number wins
// - Normal mode: stop, clear enable at end
// - Circular mode with trigger bit: restart index, keep enable
// - Source address steps when source increment set
// - Dest address steps when dest increment set
// - Width field: 1, 2 or 4 bytes
// - Trigger bit selects start on peripheral request
// - Enable bit switches channel on and off
// - Read-only item index, cleared at end
// - Start addresses held as two halves
package dmac_pkg;

  // ====================================================
  // Register map: halfword-spaced addresses; indices count halfword steps, while the bus decode gives each index its own word.
  localparam logic [31:0] DMAC_BASE = 32'h5000_3570;
  localparam logic [31:0] DMAC_OFF_ASTL = 32'h5000_3570;
  localparam logic [31:0] DMAC_OFF_ASTH = 32'h5000_3572;
  localparam logic [31:0] DMAC_OFF_BSTL = 32'h5000_3574;
  localparam logic [31:0] DMAC_OFF_BSTH = 32'h5000_3576;
  localparam logic [31:0] DMAC_OFF_THR = 32'h5000_3578;
  localparam logic [31:0] DMAC_OFF_LEN = 32'h5000_357a;
  localparam logic [31:0] DMAC_OFF_CTRL = 32'h5000_357c;
  localparam logic [31:0] DMAC_OFF_IDX = 32'h5000_357e;
  localparam logic [2:0] IX_ASTL = 3'((DMAC_OFF_ASTL - DMAC_BASE) >> 1);
  localparam logic [2:0] IX_ASTH = 3'((DMAC_OFF_ASTH - DMAC_BASE) >> 1);
  localparam logic [2:0] IX_BSTL = 3'((DMAC_OFF_BSTL - DMAC_BASE) >> 1);
  localparam logic [2:0] IX_BSTH = 3'((DMAC_OFF_BSTH - DMAC_BASE) >> 1);
  localparam logic [2:0] IX_THR = 3'((DMAC_OFF_THR - DMAC_BASE) >> 1);
  localparam logic [2:0] IX_LEN = 3'((DMAC_OFF_LEN - DMAC_BASE) >> 1);
  localparam logic [2:0] IX_CTRL = 3'((DMAC_OFF_CTRL - DMAC_BASE) >> 1);
  localparam logic [2:0] IX_IDX = 3'((DMAC_OFF_IDX - DMAC_BASE) >> 1);

  // ====================================================
  // Control register field positions and reset values.
  localparam int B_ON = 0;
  localparam int B_WIDTH = 1;
  localparam int B_IRQ_EN = 3;
  localparam int B_TRIG = 4;
  localparam int B_DST_INC = 5;
  localparam int B_SRC_INC = 6;
  localparam int B_CIRC = 7;
  localparam int B_PRIO = 8;
  localparam int B_IDLE = 11;
  localparam int B_FILL = 12;
  localparam logic [15:0] CTRL_MASK = 16'h1fff;
  localparam logic [15:0] RST_CTRL = 16'h0000;
  localparam logic [15:0] RST_THR = 16'h0000;
  localparam logic [15:0] RST_LEN = 16'h0000;
  localparam logic [15:0] RST_IDX = 16'h0000;
  localparam logic [31:0] RST_START = 32'h0000_0000;

  // ====================================================
  // Channel sequencer states, one-hot.
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_WAIT = 6'h02,
    ST_ARB = 6'h04,
    ST_READ = 6'h08,
    ST_WRITE = 6'h10,
    ST_GAP = 6'h20
  } dmac_state_e;

  // Request from the channel to the system bus.
  typedef struct packed {
    logic req;
    logic we;
    logic lock;
    logic [1:0] size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } dmac_mreq_s;

  // Answer from the system bus.
  typedef struct packed {
    logic ready;
    logic [31:0] rdata;
  } dmac_mrsp_s;

endpackage

// ==== verification/dmac_chk.sv ====
`timescale 1ns/1ps
// ====================
// Channel checker: watches the top ports only.
module dmac_chk
  import dmac_pkg::*;
#(
  parameter int NUM_CH = 8,
  parameter int CH_ID = 7,
  parameter int PAW = 6
)
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PAW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire dmac_mreq_s mreq,
  input wire dmac_mrsp_s mrsp,
  input wire logic [NUM_CH-1:0] peer_req,
  input wire logic [NUM_CH*3-1:0] peer_prio,
  input wire logic bus_req,
  input wire logic [2:0] channel_priority,
  input wire logic dreq,
  input wire logic dreq_ack,
  input wire logic irq_pulse,
  input wire logic [15:0] item_index
);
  logic [15:0] ctl_q; // Control as last written.
  logic [15:0] thr_q; // Threshold as last written.
  logic beat; // Some peer outranks this channel.
  logic wr_ok; // A store completes.
  logic wr_ctl; // Software writes control.
  assign wr_ok = mreq.req && mreq.we && mrsp.ready;
  assign wr_ctl = psel && penable && pwrite && paddr == PAW'(24);
  // Shadow registers follow software writes.
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
    begin
      ctl_q <= '0;
      thr_q <= '0;
    end
    else if (psel && penable && pwrite)
    begin
      if (paddr == PAW'(24))
        ctl_q <= pwdata[15:0];
      if (paddr == PAW'(16))
        thr_q <= pwdata[15:0];
    end
  // A peer wins on higher priority, or equal priority and lower number.
  always_comb
  begin
    beat = 1'b0;
    for (int i = 0; i < NUM_CH; i++)
      if (i != CH_ID && peer_req[i] && (peer_prio[3*i+:3] > channel_priority ||
          (peer_prio[3*i+:3] == channel_priority && i < CH_ID)))
        beat = 1'b1;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  property p_irq1; wr_ok && ctl_q[3] && item_index == thr_q |=> irq_pulse; endproperty
  a_irq1: assert property (p_irq1) else $error("missing channel interrupt");
  property p_irq2; irq_pulse |-> ctl_q[3]; endproperty
  a_irq2: assert property (p_irq2) else $error("interrupt while disabled");
  property p_fill; mreq.req && ctl_q[12] |-> mreq.lock; endproperty
  a_fill: assert property (p_fill) else $error("fill transfer lost the bus");
  property p_lock; mreq.req && !ctl_q[11] && !ctl_q[4] |-> mreq.lock; endproperty
  a_lock: assert property (p_lock) else $error("blocking copy not locked");
  property p_gap; wr_ok && ctl_q[11] && !ctl_q[4] && !ctl_q[12] |=> !mreq.req; endproperty
  a_gap: assert property (p_gap) else $error("no idle cycle after store");
  property p_arb; bus_req && beat |=> !mreq.req; endproperty
  a_arb: assert property (p_arb) else $error("won against a stronger peer");
  property p_size; mreq.req |-> mreq.size == ctl_q[2:1]; endproperty
  a_size: assert property (p_size) else $error("access size differs");
  property p_prio; wr_ctl |=> channel_priority == $past(pwdata[10:8]); endproperty
  a_prio: assert property (p_prio) else $error("priority not taken");
  property p_idx;
    wr_ok |=> item_index == $past(item_index) + 16'h0001 || item_index == 16'h0000;
  endproperty
  a_idx: assert property (p_idx) else $error("item index step wrong");
endmodule
bind dmac_channel dmac_chk #(.NUM_CH(NUM_CH), .CH_ID(CH_ID), .PAW(PAW)) chk_u (
  .mclk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .mreq, .mrsp, .peer_req, .peer_prio, .bus_req, .channel_priority,
  .dreq, .dreq_ack, .irq_pulse, .item_index);

// ==== verification/dmac_mem.sv ====
`timescale 1ns/1ps
// ====================
// Memory model: answers each access promptly or after three wait cycles, two for an access that follows straight on a ready.
module dmac_mem
  import dmac_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire dmac_mreq_s mreq,
  output dmac_mrsp_s mrsp,
  input wire logic slow
);
  logic [2:0] wait_q; // Wait cycles spent on the current access.
  // Read data is valid only with ready; otherwise it toggles.
  always @(posedge mclk or negedge resetn)
    if (!resetn)
    begin
      wait_q <= '0;
      mrsp <= '0;
    end
    else if (mreq.req && !mrsp.ready && wait_q >= (slow ? 3'd3 : 3'd0))
    begin
      mrsp.ready <= 1'b1;
      mrsp.rdata <= mreq.we ? ~mrsp.rdata : {mreq.addr[15:0] ^ 16'h5a5a, mreq.addr[15:0]};
      wait_q <= '0;
    end
    else
    begin
      mrsp.ready <= 1'b0;
      mrsp.rdata <= ~mrsp.rdata;
      wait_q <= mreq.req ? wait_q + 3'd1 : 3'd0;
    end
endmodule

// ==== verification/dmac_tb.sv ====
`timescale 1ns/1ps
// ====================
// Bench: APB master, expected access queue, peripheral request source.
module testbench
  import dmac_pkg::*;
;
  logic mclk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0, dreq = 0;
  logic trig = 0; // Peripheral requests enabled.
  logic [5:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr, bus_req, dreq_ack, irq_pulse;
  logic [7:0] peer_req = '0;
  logic [23:0] peer_prio = '0;
  logic [2:0] channel_priority;
  logic [15:0] item_index;
  dmac_mreq_s mreq;
  dmac_mrsp_s mrsp;
  logic [64:0] qx[$]; // Expected accesses: store flag, address, data.
  logic [64:0] e;
  int bad_count = 0, tests_run = 0, n_irq, n_ack, x_irq, seed = 32'h5aea;
  always #25 mclk = ~mclk;
  dmac_channel #(.NUM_CH(8), .CH_ID(7), .PAW(6)) dut_u (.mclk, .resetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .mreq, .mrsp, .peer_req,
    .peer_prio, .bus_req, .channel_priority, .dreq, .dreq_ack, .irq_pulse, .item_index);
  dmac_mem mem_u (.mclk, .resetn, .mreq, .mrsp, .slow);
  function automatic logic [31:0] pat(input logic [31:0] a);
    return {a[15:0] ^ 16'h5a5a, a[15:0]};
  endfunction
  task chk(input logic [31:0] g, input logic [31:0] x);
    tests_run++;
    if (g !== x)
    begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, g, x);
    end
  endtask
  task close_out();
    $display("compares %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // One APB transfer: setup, then access until pready.
  task apb(input logic w, input logic [5:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic er);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1)
      @(posedge mclk);
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Each finished access is checked against the model; requests follow the queue.
  always @(posedge mclk)
  begin
    if (irq_pulse === 1'b1)
      n_irq++;
    if (dreq_ack === 1'b1)
      n_ack++;
    if (resetn && mreq.req === 1'b1 && mrsp.ready === 1'b1)
    begin
      e = qx.size() != 0 ? qx.pop_front() : '1;
      chk({31'h0, mreq.we}, {31'h0, e[64]});
      chk(mreq.addr, e[63:32]);
      if (e[64])
        chk(mreq.wdata, e[31:0]);
    end
    dreq <= trig && qx.size() != 0;
  end
  // One transfer with random addresses, length and threshold.
  task automatic run(input logic [15:0] c, input logic s, input int b);
    logic [63:0] ad;
    logic [31:0] r, src;
    logic [15:0] ln, th;
    logic er;
    int sh, n;
    ad = {$random(seed), $random(seed)};
    ln = 16'($unsigned($random(seed)) % 5);
    th = 16'($unsigned($random(seed)) % 6);
    sh = c[2:1] == 2'b00 ? 0 : c[2:1] == 2'b01 ? 1 : 2;
    n_irq = 0;
    n_ack = 0;
    x_irq = 0;
    slow <= s;
    peer_req <= b != 0 ? 8'h01 : 8'h00;
    peer_prio <= {8{b == 2 ? c[10:8] - 3'd1 : c[10:8]}};
    for (int i = 0; i < 4; i++)
      apb(1, 6'(4 * i), {16'h0, ad[16*i+:16]}, r, er);
    apb(1, 6'h10, {16'h0, th}, r, er);
    apb(1, 6'h14, {16'h0, ln}, r, er);
    for (int p = 0; p < (c[7] && c[4] ? 2 : 1); p++)
      for (int k = 0; k <= ln; k++)
      begin
        src = ad[31:0] + 32'(c[6] ? k << sh : 0);
        if (!c[12] || k == 0)
          qx.push_back({1'b0, src, 32'h0});
        qx.push_back({1'b1, ad[63:32] + 32'(c[5] ? k << sh : 0), pat(c[12] ? ad[31:0] : src)});
        if (c[3] && th == k)
          x_irq++;
      end
    trig <= c[4];
    n = qx.size();
    apb(1, 6'h18, {16'h0, c}, r, er);
    if (b == 1)
    begin
      repeat (20) @(posedge mclk);
      chk(32'(qx.size()), 32'(n));
      peer_req <= 8'h00;
    end
    for (int i = 0; i < 400 && qx.size() != 0; i++)
      @(posedge mclk);
    chk(32'(qx.size()), 32'h0);
    repeat (3) @(posedge mclk);
    apb(0, 6'h18, 0, r, er);
    chk(r, {16'h0, c[7] && c[4] ? c : c & 16'hfffe});
    if (c[7] && c[4])
      apb(1, 6'h18, 0, r, er);
    trig <= 1'b0;
    chk({16'h0, item_index}, 0);
    chk(n_irq, x_irq);
    chk(n_ack, c[4] ? (c[7] ? 2 : 1) * (ln + 1) : 0);
    $display("test ctrl %h ended", c);
  endtask
  initial
  begin
    logic [31:0] r;
    logic er;
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    for (int i = 4; i < 8; i++)
    begin
      apb(0, 6'(4 * i), 0, r, er);
      chk(r, 0);
    end
    apb(0, 6'h20, 0, r, er);
    chk({r[30:0], er}, 32'h1);
    apb(1, 6'h1c, 32'h1234, r, er);
    apb(0, 6'h1c, 0, r, er);
    chk(r, 0);
    apb(1, 6'h14, 32'hffffabcd, r, er);
    apb(0, 6'h14, 0, r, er);
    chk(r, 32'h0000abcd);
    $display("test registers ended");
    run(16'h0069, 0, 0);
    run(16'h054b, 1, 0);
    run(16'h082d, 1, 0);
    run(16'h026f, 0, 0);
    run(16'h186d, 1, 0);
    run(16'h08fb, 1, 0);
    run(16'h0061, 0, 1);
    run(16'h0361, 0, 2);
    for (int i = 0; i < 4; i++)
    begin
      r = $random(seed);
      run((r[15:0] & 16'h0f6e) | 16'h0001, r[9], 0);
    end
    close_out();
  end
  initial
  begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    close_out();
  end
endmodule
